// ---- core/vpi_params.svh ----
`ifndef VPI_PARAMS_SVH
`define VPI_PARAMS_SVH
// ==========================================
// Vector space
`define VPI_NUM_VEC      38
`define VPI_VEC_W        6
`define VPI_LVL_W        2
`define VPI_ADDR_W       19
`define VPI_SLOT_SHIFT   1
// ==========================================
// Vector numbers
`define VPI_SLOT_RESET   6'h00
`define VPI_SLOT_WDOG    6'h01
`define VPI_EXC_LO       6'h02
`define VPI_EXC_HI       6'h05
`define VPI_DBG_LO       6'h06
`define VPI_DBG_HI       6'h0A
`define VPI_SWI2         6'h0B
`define VPI_SWI1         6'h0C
`define VPI_SWI0         6'h0D
`define VPI_PER_LO       6'h10
`define VPI_PER_HI       6'h25
`define VPI_POWER        6'h10
`define VPI_CLK_SYNTH    6'h11
`define VPI_FLASH_LO     6'h12
`define VPI_FLASH_HI     6'h14
`define VPI_GPIO_LO      6'h16
`define VPI_GPIO_HI      6'h19
`define VPI_SPI_RX       6'h1A
`define VPI_SPI_TX       6'h1B
`define VPI_SERIAL_LO    6'h1C
`define VPI_SERIAL_HI    6'h20
`define VPI_I2C          6'h23
`define VPI_TIMER_LO     6'h24
`define VPI_TIMER_HI     6'h25
// ==========================================
// Priority levels
`define VPI_LVL_0        2'h0
`define VPI_LVL_1        2'h1
`define VPI_LVL_2        2'h2
`define VPI_LVL_3        2'h3
`endif

// ---- core/vpi_pkg.sv ----
`include "vpi_params.svh"
package vpi_pkg;
  typedef logic [`VPI_VEC_W-1:0]  vpi_vec_type;
  typedef logic [`VPI_LVL_W-1:0]  vpi_lvl_type;
  typedef logic [`VPI_ADDR_W-1:0] vpi_addr_type;

  typedef enum logic [2:0] {
    VPI_ST_STRAP = 3'h0,
    VPI_ST_BOOT  = 3'h1,
    VPI_ST_IDLE  = 3'h3,
    VPI_ST_OFFER = 3'h2,
    VPI_ST_TAKEN = 3'h6
  } vpi_state_type;

  // ==========================================
  // Clamp a programmed level into its legal range
  function automatic vpi_lvl_type vpi_clamp_level(input vpi_lvl_type lvl,
                                                  input vpi_lvl_type lo,
                                                  input vpi_lvl_type hi);
    vpi_lvl_type res;
    res = lvl;
    if (lvl < lo) res = lo;
    if (lvl > hi) res = hi;
    return res;
  endfunction : vpi_clamp_level

  // ==========================================
  // Slot address: two program words per vector
  function automatic vpi_addr_type vpi_slot_addr(input vpi_addr_type base,
                                                 input vpi_vec_type  vec);
    vpi_addr_type ofs;
    ofs = vpi_addr_type'(vec) << `VPI_SLOT_SHIFT;
    return vpi_addr_type'(base + ofs);
  endfunction : vpi_slot_addr
endpackage : vpi_pkg

// ---- core/vpi_arb_if.sv ----
`timescale 1ns/1ps
`include "vpi_params.svh"
interface vpi_arb_if;
  logic [`VPI_NUM_VEC-1:0]                 req;
  logic [`VPI_NUM_VEC-1:0][`VPI_LVL_W-1:0] level;
  vpi_pkg::vpi_lvl_type                    mask_level;
  logic                                    win_valid;
  vpi_pkg::vpi_vec_type                    win_vec;
  vpi_pkg::vpi_lvl_type                    win_level;

  modport requester (output req, level, mask_level,
                     input  win_valid, win_vec, win_level);
  modport arbiter   (input  req, level, mask_level,
                     output win_valid, win_vec, win_level);
endinterface : vpi_arb_if

// ---- core/vpi_arbiter.sv ----
`timescale 1ns/1ps
`include "vpi_params.svh"
module vpi_arbiter (
  // Request side
  vpi_arb_if.arbiter arb
);
  // ==========================================
  // Highest level wins; ties go to the lowest vector
  always_comb begin
    logic                 found;
    vpi_pkg::vpi_vec_type best_vec;
    vpi_pkg::vpi_lvl_type best_lvl;
    found    = 1'b0;
    best_vec = '0;
    best_lvl = '0;
    // Scan downward so an equal level at a lower vector replaces the holder
    for (int v = `VPI_NUM_VEC - 1; v >= 0; v--) begin
      if (arb.req[v] && (arb.level[v] >= arb.mask_level)) begin
        if (!found || (arb.level[v] >= best_lvl)) begin // R1 R2
          found    = 1'b1;
          best_vec = vpi_pkg::vpi_vec_type'(v);
          best_lvl = arb.level[v];
        end
      end
    end
    arb.win_valid = found;
    arb.win_vec   = best_vec;
    arb.win_level = best_lvl;
  end
endmodule : vpi_arbiter

// ---- core/vpi_top.sv ----
// Contract
// R1: Higher level served before every lower level
// R2: Equal level: lowest vector number wins
// R3: Peripheral and debug levels are programmable
// R4: Vector addresses formed from programmable table base
// R5: Base zero: reset slot 0, watchdog slot 1
// R6: Software fills slots with jumps and calls
// R7: Slots 0 and 1 never carry interrupts
// R8: Core exceptions 2 to 5 fixed level 3
// R9: Debug vectors 6 to 10 levels 1-3
// R10: Peripheral vectors, clock synthesis 17, levels 0-2
// R11: Flash vectors 18, 19, 20 separate
// R12: SPI receive on 26, transmit on 27
// R13: Slot is base plus twice vector, 19 bits
// R14: Reserved vectors 14,15,21,33,34 never raised
`timescale 1ns/1ps
`include "vpi_params.svh"
module vpi_top #(
  parameter int ADDR_W = `VPI_ADDR_W
) (
  // Clock and reset
  input  wire logic                                 i_mclk,
  input  wire logic                                 i_resetn,
  // Configuration
  input  wire logic [ADDR_W-1:0]                    i_vector_table_base,
  input  wire logic [`VPI_LVL_W-1:0]                i_mask_level,
  input  wire logic [5*`VPI_LVL_W-1:0]              i_debug_level,
  input  wire logic [22*`VPI_LVL_W-1:0]             i_periph_level,
  input  wire logic                                 i_wdog_reset_flag,
  // Core exception, debug and software requests
  input  wire logic [3:0]                           i_core_exc_req,
  input  wire logic [4:0]                           i_debug_req,
  input  wire logic [2:0]                           i_swi_req,
  // Peripheral requests
  input  wire logic                                 i_power_sense_req,
  input  wire logic                                 i_clock_synthesis_unit_req,
  input  wire logic [2:0]                           i_flash_module_req,
  input  wire logic [3:0]                           i_gpio_req,
  input  wire logic                                 i_spi_rx_req,
  input  wire logic                                 i_spi_tx_req,
  input  wire logic [4:0]                           i_serial_comms_port_req,
  input  wire logic                                 i_i2c_req,
  input  wire logic [1:0]                           i_timer_req,
  // Core fetch handshake
  input  wire logic                                 i_boot_ack,
  input  wire logic                                 i_irq_ack,
  // Boot fetch
  output logic                                      o_boot_valid,
  output logic                                      o_boot_wdog,
  output logic [ADDR_W-1:0]                         o_boot_addr,
  // Interrupt offer
  output logic                                      o_irq_valid,
  output logic [`VPI_VEC_W-1:0]                     o_irq_vector,
  output logic [`VPI_LVL_W-1:0]                     o_irq_level,
  output logic [ADDR_W-1:0]                         o_irq_addr,
  output logic [`VPI_NUM_VEC-1:0]                   o_src_ack
);

  vpi_pkg::vpi_state_type state;
  vpi_pkg::vpi_state_type next_state;
  logic                   wdog_seen;
  logic                   offer_load;
  logic                   offer_take;

  vpi_arb_if arb ();

  // ==========================================
  // Request map
  always_comb begin
    arb.req = '0;
    arb.req[`VPI_EXC_HI:`VPI_EXC_LO]       = i_core_exc_req;
    arb.req[`VPI_DBG_HI:`VPI_DBG_LO]       = i_debug_req;
    arb.req[`VPI_SWI2]                     = i_swi_req[2];
    arb.req[`VPI_SWI1]                     = i_swi_req[1];
    arb.req[`VPI_SWI0]                     = i_swi_req[0];
    arb.req[`VPI_POWER]                    = i_power_sense_req;
    arb.req[`VPI_CLK_SYNTH]                = i_clock_synthesis_unit_req; // R10
    arb.req[`VPI_FLASH_HI:`VPI_FLASH_LO]   = i_flash_module_req; // R11
    arb.req[`VPI_GPIO_HI:`VPI_GPIO_LO]     = i_gpio_req;
    arb.req[`VPI_SPI_RX]                   = i_spi_rx_req; // R12
    arb.req[`VPI_SPI_TX]                   = i_spi_tx_req; // R12
    arb.req[`VPI_SERIAL_HI:`VPI_SERIAL_LO] = i_serial_comms_port_req;
    arb.req[`VPI_I2C]                      = i_i2c_req;
    arb.req[`VPI_TIMER_HI:`VPI_TIMER_LO]   = i_timer_req;
    // Reset slots and reserved vectors stay tied low
    arb.req[`VPI_SLOT_RESET] = 1'b0; // R7
    arb.req[`VPI_SLOT_WDOG]  = 1'b0; // R7
    arb.req[6'h0E]           = 1'b0; // R14
    arb.req[6'h0F]           = 1'b0; // R14
    arb.req[6'h15]           = 1'b0; // R14
    arb.req[6'h21]           = 1'b0; // R14
    arb.req[6'h22]           = 1'b0; // R14
  end

  // ==========================================
  // Level map
  always_comb begin
    arb.level = '0;
    for (int v = `VPI_EXC_LO; v <= `VPI_EXC_HI; v++) begin
      arb.level[v] = `VPI_LVL_3; // R8
    end
    for (int d = 0; d < 5; d++) begin
      arb.level[`VPI_DBG_LO + d] = vpi_pkg::vpi_clamp_level(
        i_debug_level[d*`VPI_LVL_W +: `VPI_LVL_W],
        `VPI_LVL_1, `VPI_LVL_3); // R3 R9
    end
    arb.level[`VPI_SWI2] = `VPI_LVL_2;
    arb.level[`VPI_SWI1] = `VPI_LVL_1;
    arb.level[`VPI_SWI0] = `VPI_LVL_0;
    for (int p = 0; p < 22; p++) begin
      arb.level[`VPI_PER_LO + p] = vpi_pkg::vpi_clamp_level(
        i_periph_level[p*`VPI_LVL_W +: `VPI_LVL_W],
        `VPI_LVL_0, `VPI_LVL_2); // R3 R10
    end
  end

  assign arb.mask_level = i_mask_level;

  vpi_arbiter u_arbiter (
    .arb (arb)
  );

  // ==========================================
  // Sequencer
  assign offer_take = (state == vpi_pkg::VPI_ST_OFFER) && i_irq_ack;
  assign offer_load = ((state == vpi_pkg::VPI_ST_IDLE) ||
                       (state == vpi_pkg::VPI_ST_OFFER)) &&
                      arb.win_valid && !offer_take;

  always_comb begin
    next_state = state;
    case (state)
      vpi_pkg::VPI_ST_STRAP: begin
        next_state = vpi_pkg::VPI_ST_BOOT;
      end
      vpi_pkg::VPI_ST_BOOT: begin
        if (o_boot_valid && i_boot_ack) begin
          next_state = vpi_pkg::VPI_ST_IDLE;
        end
      end
      vpi_pkg::VPI_ST_IDLE: begin
        if (arb.win_valid) begin
          next_state = vpi_pkg::VPI_ST_OFFER;
        end
      end
      vpi_pkg::VPI_ST_OFFER: begin
        if (i_irq_ack) begin
          next_state = vpi_pkg::VPI_ST_TAKEN;
        end else if (!arb.win_valid) begin
          next_state = vpi_pkg::VPI_ST_IDLE;
        end
      end
      vpi_pkg::VPI_ST_TAKEN: begin
        next_state = vpi_pkg::VPI_ST_IDLE;
      end
      default: begin
        next_state = vpi_pkg::VPI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= vpi_pkg::VPI_ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // Reset cause, caught one cycle after release
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdog_seen <= 1'b0;
    end else if (state == vpi_pkg::VPI_ST_STRAP) begin
      wdog_seen <= i_wdog_reset_flag;
    end
  end

  // ==========================================
  // Boot fetch
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boot_valid <= 1'b0;
      o_boot_wdog  <= 1'b0;
      o_boot_addr  <= '0;
    end else if (state == vpi_pkg::VPI_ST_STRAP) begin
      o_boot_valid <= 1'b0;
    end else if (state == vpi_pkg::VPI_ST_BOOT) begin
      if (o_boot_valid && i_boot_ack) begin
        o_boot_valid <= 1'b0;
      end else begin
        o_boot_valid <= 1'b1;
        o_boot_wdog  <= wdog_seen;
        o_boot_addr  <= vpi_pkg::vpi_slot_addr(i_vector_table_base,
                          wdog_seen ? `VPI_SLOT_WDOG : `VPI_SLOT_RESET); // R4 R5
      end
    end
  end

  // ==========================================
  // Interrupt offer; a new winner replaces the offer until taken
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_valid <= 1'b0;
    end else if (offer_load) begin
      o_irq_valid <= 1'b1;
    end else begin
      o_irq_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_vector <= '0;
      o_irq_level  <= '0;
      o_irq_addr   <= '0;
    end else if (offer_load) begin
      o_irq_vector <= arb.win_vec; // R1 R2
      o_irq_level  <= arb.win_level;
      o_irq_addr   <= vpi_pkg::vpi_slot_addr(i_vector_table_base,
                                             arb.win_vec); // R4 R13
    end
  end

  // ==========================================
  // Source acknowledge, one cycle per taken vector
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_src_ack <= '0;
    end else begin
      o_src_ack <= '0;
      if (offer_take) begin
        o_src_ack[o_irq_vector] <= 1'b1;
      end
    end
  end

endmodule : vpi_top

// ---- sim/vpi_props_properties.sv ----
`timescale 1ns/1ps
module vpi_props #(
  parameter int ADDR_W = 19
) (
  // Clock and reset
  input wire logic              i_mclk,
  input wire logic              i_resetn,
  // Watched inputs
  input wire logic [ADDR_W-1:0] i_vector_table_base,
  input wire logic [3:0]        i_core_exc_req,
  input wire logic              i_boot_ack,
  input wire logic              i_irq_ack,
  // Watched outputs
  input wire logic              o_boot_valid,
  input wire logic              o_boot_wdog,
  input wire logic [ADDR_W-1:0] o_boot_addr,
  input wire logic              o_irq_valid,
  input wire logic [5:0]        o_irq_vector,
  input wire logic [1:0]        o_irq_level,
  input wire logic [ADDR_W-1:0] o_irq_addr,
  input wire logic [37:0]       o_src_ack
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ==========
  // Boot fetch
  boot_addr_a: assert property (
    o_boot_valid |-> o_boot_addr == ADDR_W'(i_vector_table_base + (o_boot_wdog ? 2 : 0)))
    else $error("boot address wrong");
  boot_hold_a: assert property (
    o_boot_valid && !i_boot_ack |=> o_boot_valid && $stable(o_boot_addr))
    else $error("boot fetch not held");
  // ==========
  // Interrupt offer
  irq_addr_a: assert property (
    o_irq_valid |-> o_irq_addr == ADDR_W'(i_vector_table_base + 2 * o_irq_vector))
    else $error("offer address wrong");
  take_ack_a: assert property (
    o_irq_valid && i_irq_ack |=> o_src_ack == (38'h1 << $past(o_irq_vector)) && !o_irq_valid
    ##1 !o_irq_valid && o_src_ack == 38'h0)
    else $error("take acknowledge wrong");
  no_reserved_a: assert property (
    o_irq_valid |-> !(o_irq_vector inside {0, 1, 14, 15, 21, 33, 34}))
    else $error("reserved vector offered");
  exc_level_a: assert property (
    o_irq_valid && o_irq_vector inside {[2:5]} |-> o_irq_level == 2'h3)
    else $error("exception level wrong");
  dbg_level_a: assert property (
    o_irq_valid && o_irq_vector inside {[6:10]} |-> o_irq_level != 2'h0)
    else $error("debug level out of range");
  per_level_a: assert property (
    o_irq_valid && o_irq_vector >= 6'h10 |-> o_irq_level != 2'h3)
    else $error("peripheral level out of range");
  exc_first_a: assert property (
    o_irq_valid && $past(i_core_exc_req) != 4'h0 |-> o_irq_level == 2'h3)
    else $error("lower level beat exception");
  cover property (o_irq_valid && i_irq_ack);
  cover property (o_boot_valid && o_boot_wdog);
  cover property (o_irq_valid && o_irq_level == 2'h0);
endmodule : vpi_props

bind vpi_top vpi_props #(.ADDR_W(ADDR_W)) chk_u (.*);

// ---- sim/vpi_core_model.sv ----
`timescale 1ns/1ps
module vpi_core_model (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  // Control
  input  wire logic i_go,
  input  wire logic i_slow,
  // Fetch requests
  input  wire logic i_boot_valid,
  input  wire logic i_irq_valid,
  output logic      o_boot_ack,
  output logic      o_irq_ack
);
  int unsigned wait_cnt;

  // One acknowledge per boot fetch and per offer, on the falling edge
  always @(negedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boot_ack <= 1'b0;
      o_irq_ack  <= 1'b0;
      wait_cnt   <= 0;
    end else begin
      o_boot_ack <= i_boot_valid && !o_boot_ack;
      wait_cnt   <= (i_irq_valid && i_go && !o_irq_ack) ? wait_cnt + 1 : 0;
      o_irq_ack  <= i_irq_valid && i_go && !o_irq_ack && wait_cnt >= (i_slow ? 3 : 0);
    end
  end
endmodule : vpi_core_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  // ==========
  // Design signals
  logic        i_mclk, i_resetn, i_wdog_reset_flag, i_boot_ack, i_irq_ack;
  logic [18:0] i_vector_table_base, o_boot_addr, o_irq_addr;
  logic [1:0]  i_mask_level, o_irq_level;
  logic [9:0]  i_debug_level;
  logic [43:0] i_periph_level;
  logic [37:0] req, o_src_ack;
  logic        o_boot_valid, o_boot_wdog, o_irq_valid, go, slow;
  logic [5:0]  o_irq_vector;
  int          mismatches, total_checks;
  wire logic [3:0] i_core_exc_req = req[5:2];
  wire logic [4:0] i_debug_req = req[10:6];
  wire logic [2:0] i_swi_req = {req[11], req[12], req[13]};
  wire logic       i_power_sense_req = req[16];
  wire logic       i_clock_synthesis_unit_req = req[17];
  wire logic [2:0] i_flash_module_req = req[20:18];
  wire logic [3:0] i_gpio_req = req[25:22];
  wire logic       i_spi_rx_req = req[26];
  wire logic       i_spi_tx_req = req[27];
  wire logic [4:0] i_serial_comms_port_req = req[32:28];
  wire logic       i_i2c_req = req[35];
  wire logic [1:0] i_timer_req = req[37:36];

  vpi_top dut_u (.*);
  vpi_core_model core_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_go(go), .i_slow(slow),
    .i_boot_valid(o_boot_valid), .i_irq_valid(o_irq_valid),
    .o_boot_ack(i_boot_ack), .o_irq_ack(i_irq_ack));

  // ==========
  // Shared tasks
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic boot(input logic wdog, input logic [18:0] exp);
    int n;
    n = 0;
    i_resetn = 1'b0;
    i_wdog_reset_flag = wdog;
    repeat (10) @(negedge i_mclk);
    i_resetn = 1'b1;
    while (o_boot_valid !== 1'b1 && n < 20) begin
      @(negedge i_mclk);
      n++;
    end
    chk(o_boot_addr, exp);
    chk(o_boot_wdog, wdog);
    while (o_boot_valid !== 1'b0 && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    chk(o_boot_valid, 1'b0);
  endtask : boot

  // Wait for the offer, check it, let the core take it, drop the source
  task automatic take(input logic [5:0] v, input logic [1:0] l);
    int n;
    n = 0;
    while (o_irq_valid !== 1'b1 && n < 20) begin
      @(negedge i_mclk);
      n++;
    end
    chk(o_irq_vector, v);
    chk(o_irq_level, l);
    chk(o_irq_addr, 19'(i_vector_table_base + 2 * v));
    go <= 1'b1;
    while (o_src_ack === 38'h0 && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    chk(o_src_ack, 38'h1 << v);
    req[v] = 1'b0;
    go <= 1'b0;
  endtask : take

  // ==========
  // Scenarios
  task automatic sc_levels();
    req = 38'h00_0002_3848;
    take(6'h03, 2'h3);
    take(6'h0B, 2'h2);
    take(6'h11, 2'h2);
    take(6'h06, 2'h1);
    take(6'h0C, 2'h1);
    take(6'h0D, 2'h0);
  endtask : sc_levels

  // Debug level 0 and peripheral level 3 are clamped
  task automatic sc_clamp();
    req = 38'h00_0C00_0080;
    take(6'h1A, 2'h2);
    take(6'h1B, 2'h2);
    take(6'h07, 2'h1);
  endtask : sc_clamp

  task automatic sc_flash();
    req = 38'h00_001C_0120;
    take(6'h05, 2'h3);
    take(6'h08, 2'h1);
    take(6'h12, 2'h1);
    take(6'h13, 2'h1);
    take(6'h14, 2'h1);
  endtask : sc_flash

  task automatic sc_periph();
    for (int v = 16; v < 38; v++) begin
      if (v inside {16, [22:25], [28:32], [35:37]}) req[v] = 1'b1;
    end
    for (int v = 16; v < 38; v++) begin
      if (v inside {16, [22:25], [28:32], [35:37]}) take(6'(v), 2'h0);
    end
  endtask : sc_periph

  task automatic sc_mask();
    i_mask_level = 2'h2;
    req[13] = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk(o_irq_valid, 1'b0);
    i_mask_level = 2'h0;
    take(6'h0D, 2'h0);
  endtask : sc_mask

  // ==========
  // Clock, watchdog and main sequence
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial begin
    i_resetn = 1'b0;
    req = 38'h0;
    go = 1'b0;
    slow = 1'b1;
    i_mask_level = 2'h0;
    i_wdog_reset_flag = 1'b0;
    i_vector_table_base = 19'h0_0000;
    i_debug_level = 10'h001;
    // Vec17 level 2, vec18..20 level 1, vec26 level 2, vec27 level 3
    i_periph_level = 44'h000_00E0_0158;
    boot(1'b0, 19'h0_0000);
    boot(1'b1, 19'h0_0002);
    i_vector_table_base = 19'h7_FFF0;
    sc_levels();
    slow = 1'b0;
    sc_clamp();
    sc_flash();
    sc_periph();
    sc_mask();
    finish_test();
  end
endmodule : tb
